//--- design/hcpm_pkg.sv
package hcpm_pkg;
  localparam logic [7:0] OFS_WB_LO = 8'h88;
  localparam logic [7:0] OFS_WB_HI = 8'h8C;
  localparam logic [7:0] OFS_MASK = 8'h90;
  localparam logic [7:0] OFS_MASK_SET = 8'h94;
  localparam logic [7:0] OFS_MASK_CLR = 8'h98;
  localparam logic [7:0] OFS_PMON_CTRL = 8'hC0;
  localparam logic [7:0] OFS_CYC_LO = 8'hC4;
  localparam logic [7:0] OFS_CYC_HI = 8'hC8;
  localparam logic [7:0] OFS_DAT_LO = 8'hCC;
  localparam logic [7:0] OFS_DAT_HI = 8'hD0;
  localparam logic [7:0] OFS_RUN_CTRL = 8'hD4;
  // Implemented mask bits: 23:9 and 6:1
  localparam logic [31:0] MASK_VALID = 32'h00FF_FE7E;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] WB_RESET = 32'h0000_0000;
  localparam int PMON_ARM_BIT = 2;
  localparam int PMON_CLR_BIT = 1;
  localparam int PMON_AUTO_BIT = 0;
  localparam int CNT_WIDTH = 42;
  localparam int MAXED_BIT = 16;
  localparam logic [41:0] CNT_RESET = 42'h000_0000_0000;
  localparam int RUN_BIT = 0;
  localparam int MF_DESC_LSB = 19;
  localparam int MF_OUT_LSB = 14;
  localparam int MF_IN_LSB = 9;
  localparam int MF_FIELD_W = 5;
  localparam int MB_HALT_QUIET = 6;
  localparam int MB_BAD_SIZE = 5;
  localparam int MB_BAD_SIG = 4;
  localparam int MB_MISALIGN = 3;
  localparam int MB_MARK_DONE = 2;
  localparam int MB_MARK_HALT = 1;
endpackage

//--- design/hcpm_regs.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module hcpm_regs #(
  parameter int CNT_W = hcpm_pkg::CNT_WIDTH
) (
  // Clock and reset
  input wire logic refClk,
  input wire logic sysRst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  // Channel events, same clock
  input wire logic [31:0] statusLogged,
  input wire logic descHaltDone,
  input wire logic readBeatValid,
  // Block outputs
  output logic chanRun,
  output logic [63:0] wbAddr,
  output logic irqReq
);
  typedef struct packed {
    logic [31:0] wbLo;
    logic [31:0] wbHi;
    logic [31:0] mask;
    logic arm;
    logic auto;
    logic run;
    logic [CNT_W-1:0] cyc;
    logic [CNT_W-1:0] dat;
    logic cycMax;
    logic datMax;
    logic [31:0] rd;
    logic irq;
  } hcpm_state_t;

  hcpm_state_t st_ff, nxt_st;
  localparam logic [CNT_W-1:0] CNT_ONES = {CNT_W{1'b1}};

  function automatic logic isWr(input logic [7:0] a, input logic [7:0] o, input logic s);
    isWr = s && (a == o);
  endfunction

  function automatic logic [31:0] hiWord(input logic [CNT_W-1:0] c, input logic m);
    logic [31:0] w;
    w = 32'(c >> 32);
    w[hcpm_pkg::MAXED_BIT] = m;
    hiWord = w;
  endfunction

  // Request from the enabled fields only; reserved mask bits never contribute
  function automatic logic irqFromFields(input logic [31:0] sts, input logic [31:0] msk);
    logic [31:0] hit;
    logic req;
    hit = sts & msk;
    req = |hit[hcpm_pkg::MF_DESC_LSB +: hcpm_pkg::MF_FIELD_W];
    req = req | (|hit[hcpm_pkg::MF_IN_LSB +: hcpm_pkg::MF_FIELD_W]);
    req = req | (|hit[hcpm_pkg::MF_OUT_LSB +: hcpm_pkg::MF_FIELD_W]);
    req = req | hit[hcpm_pkg::MB_HALT_QUIET];
    req = req | hit[hcpm_pkg::MB_BAD_SIZE];
    req = req | hit[hcpm_pkg::MB_BAD_SIG];
    req = req | hit[hcpm_pkg::MB_MISALIGN];
    req = req | hit[hcpm_pkg::MB_MARK_DONE];
    req = req | hit[hcpm_pkg::MB_MARK_HALT];
    irqFromFields = req;
  endfunction

  logic runRise;
  logic counting;
  logic pmonClr;
  assign runRise = nxt_st.run && !st_ff.run;
  assign counting = st_ff.arm && st_ff.run;
  assign pmonClr = isWr(regAddr, hcpm_pkg::OFS_PMON_CTRL, regWrStb) && regWrData[hcpm_pkg::PMON_CLR_BIT];

  // Registered mask split into its named enable fields
  logic [hcpm_pkg::MF_FIELD_W-1:0] maskDescriptorFault;
  logic [hcpm_pkg::MF_FIELD_W-1:0] maskOutboundFault;
  logic [hcpm_pkg::MF_FIELD_W-1:0] maskInboundFault;
  logic maskHaltWhenQuiet;
  logic maskBadSize;
  logic maskBadSignature;
  logic maskMisaligned;
  logic maskMarkedDone;
  logic maskMarkedHalt;
  assign maskDescriptorFault = st_ff.mask[hcpm_pkg::MF_DESC_LSB +: hcpm_pkg::MF_FIELD_W];
  assign maskOutboundFault = st_ff.mask[hcpm_pkg::MF_OUT_LSB +: hcpm_pkg::MF_FIELD_W];
  assign maskInboundFault = st_ff.mask[hcpm_pkg::MF_IN_LSB +: hcpm_pkg::MF_FIELD_W];
  assign maskHaltWhenQuiet = st_ff.mask[hcpm_pkg::MB_HALT_QUIET];
  assign maskBadSize = st_ff.mask[hcpm_pkg::MB_BAD_SIZE];
  assign maskBadSignature = st_ff.mask[hcpm_pkg::MB_BAD_SIG];
  assign maskMisaligned = st_ff.mask[hcpm_pkg::MB_MISALIGN];
  assign maskMarkedDone = st_ff.mask[hcpm_pkg::MB_MARK_DONE];
  assign maskMarkedHalt = st_ff.mask[hcpm_pkg::MB_MARK_HALT];

  always_comb begin
    nxt_st = st_ff;
    // Writeback address
    if (isWr(regAddr, hcpm_pkg::OFS_WB_LO, regWrStb)) begin
      nxt_st.wbLo = regWrData;
    end
    if (isWr(regAddr, hcpm_pkg::OFS_WB_HI, regWrStb)) begin
      nxt_st.wbHi = regWrData;
    end
    // Mask, direct and aliases; reserved bits forced low
    if (isWr(regAddr, hcpm_pkg::OFS_MASK, regWrStb)) begin
      nxt_st.mask = regWrData & hcpm_pkg::MASK_VALID;
    end
    if (isWr(regAddr, hcpm_pkg::OFS_MASK_SET, regWrStb)) begin
      nxt_st.mask = st_ff.mask | (regWrData & hcpm_pkg::MASK_VALID);
    end
    if (isWr(regAddr, hcpm_pkg::OFS_MASK_CLR, regWrStb)) begin
      nxt_st.mask = st_ff.mask & ~regWrData;
    end
    // Channel run control
    if (isWr(regAddr, hcpm_pkg::OFS_RUN_CTRL, regWrStb)) begin
      nxt_st.run = regWrData[hcpm_pkg::RUN_BIT];
    end
    // Monitor control
    if (isWr(regAddr, hcpm_pkg::OFS_PMON_CTRL, regWrStb)) begin
      nxt_st.arm = regWrData[hcpm_pkg::PMON_ARM_BIT];
      nxt_st.auto = regWrData[hcpm_pkg::PMON_AUTO_BIT];
    end
    if (st_ff.auto && descHaltDone && counting) begin
      nxt_st.arm = 1'b0;
    end
    // Counters count only while armed and channel running
    if (counting) begin
      if (st_ff.cyc != CNT_ONES) begin
        nxt_st.cyc = st_ff.cyc + 1'b1;
      end
      if (readBeatValid && st_ff.dat != CNT_ONES) begin
        nxt_st.dat = st_ff.dat + 1'b1;
      end
    end
    if (nxt_st.cyc == CNT_ONES) begin
      nxt_st.cycMax = 1'b1;
    end
    if (nxt_st.dat == CNT_ONES) begin
      nxt_st.datMax = 1'b1;
    end
    if (pmonClr || (st_ff.auto && runRise)) begin
      nxt_st.cyc = CNT_W'(hcpm_pkg::CNT_RESET);
      nxt_st.dat = CNT_W'(hcpm_pkg::CNT_RESET);
      nxt_st.cycMax = 1'b0;
      nxt_st.datMax = 1'b0;
    end
    // Interrupt level from logged status and mask
    nxt_st.irq = irqFromFields(statusLogged, nxt_st.mask);
    // Read data, valid only in cycle after strobe
    nxt_st.rd = 32'h0000_0000;
    if (regRdStb) begin
      case (regAddr)
        hcpm_pkg::OFS_WB_LO: nxt_st.rd = st_ff.wbLo;
        hcpm_pkg::OFS_WB_HI: nxt_st.rd = st_ff.wbHi;
        hcpm_pkg::OFS_MASK: nxt_st.rd = st_ff.mask;
        hcpm_pkg::OFS_PMON_CTRL: begin
          nxt_st.rd[hcpm_pkg::PMON_ARM_BIT] = st_ff.arm;
          nxt_st.rd[hcpm_pkg::PMON_AUTO_BIT] = st_ff.auto;
        end
        hcpm_pkg::OFS_CYC_LO: nxt_st.rd = 32'(st_ff.cyc);
        hcpm_pkg::OFS_CYC_HI: nxt_st.rd = hiWord(st_ff.cyc, st_ff.cycMax);
        hcpm_pkg::OFS_DAT_LO: nxt_st.rd = 32'(st_ff.dat);
        hcpm_pkg::OFS_DAT_HI: nxt_st.rd = hiWord(st_ff.dat, st_ff.datMax);
        hcpm_pkg::OFS_RUN_CTRL: nxt_st.rd[hcpm_pkg::RUN_BIT] = st_ff.run;
        default: nxt_st.rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge refClk) begin
    if (sysRst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rd;
  assign chanRun = st_ff.run;
  assign wbAddr = {st_ff.wbHi, st_ff.wbLo};
  assign irqReq = st_ff.irq;

  // Writeback address
  AST_WB_HI_WRITE: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_WB_HI, regWrStb)
    |=> wbAddr[63:32] == $past(regWrData))
    else $error("upper writeback word not stored");

  AST_WB_LO_WRITE: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_WB_LO, regWrStb)
    |=> wbAddr[31:0] == $past(regWrData))
    else $error("lower writeback word not stored");

  AST_WB_HOLD: assert property (@(posedge refClk) disable iff (sysRst)
    !isWr(regAddr, hcpm_pkg::OFS_WB_HI, regWrStb) && !isWr(regAddr, hcpm_pkg::OFS_WB_LO, regWrStb)
    |=> $stable(wbAddr))
    else $error("writeback address changed without a write");

  // Mask and interrupt request
  AST_MASK_DIRECT: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_MASK, regWrStb)
    |=> st_ff.mask == ($past(regWrData) & hcpm_pkg::MASK_VALID))
    else $error("mask write not stored");

  AST_MASK_RSVD: assert property (@(posedge refClk) disable iff (sysRst)
    (st_ff.mask & ~hcpm_pkg::MASK_VALID)
    == 32'h0000_0000)
    else $error("reserved mask bit set");

  AST_MASK_SET: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_MASK_SET, regWrStb)
    |=> st_ff.mask == ($past(st_ff.mask) | ($past(regWrData) & hcpm_pkg::MASK_VALID)))
    else $error("mask set alias wrong");

  AST_MASK_CLR: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_MASK_CLR, regWrStb)
    |=> st_ff.mask == ($past(st_ff.mask) & ~$past(regWrData)))
    else $error("mask clear alias wrong");

  AST_IRQ_LEVEL: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 irqReq
    == |($past(statusLogged) & st_ff.mask))
    else $error("interrupt level mismatch");

  AST_IRQ_DESC_FAULT: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !(|($past(statusLogged[hcpm_pkg::MF_DESC_LSB +: hcpm_pkg::MF_FIELD_W]) & maskDescriptorFault))
    || irqReq)
    else $error("descriptor fault enable ignored");

  AST_IRQ_INBOUND: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !(|($past(statusLogged[hcpm_pkg::MF_IN_LSB +: hcpm_pkg::MF_FIELD_W]) & maskInboundFault))
    || irqReq)
    else $error("inbound fault enable ignored");

  AST_IRQ_OUTBOUND: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !(|($past(statusLogged[hcpm_pkg::MF_OUT_LSB +: hcpm_pkg::MF_FIELD_W]) & maskOutboundFault))
    || irqReq)
    else $error("outbound fault enable ignored");

  AST_IRQ_HALT_QUIET: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !($past(statusLogged[hcpm_pkg::MB_HALT_QUIET]) && maskHaltWhenQuiet)
    || irqReq)
    else $error("quiet halt enable ignored");

  AST_IRQ_BAD_SIZE: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !($past(statusLogged[hcpm_pkg::MB_BAD_SIZE]) && maskBadSize)
    || irqReq)
    else $error("bad size enable ignored");

  AST_IRQ_BAD_SIG: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !($past(statusLogged[hcpm_pkg::MB_BAD_SIG]) && maskBadSignature)
    || irqReq)
    else $error("bad signature enable ignored");

  AST_IRQ_MISALIGN: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !($past(statusLogged[hcpm_pkg::MB_MISALIGN]) && maskMisaligned)
    || irqReq)
    else $error("misaligned enable ignored");

  AST_IRQ_MARK_DONE: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !($past(statusLogged[hcpm_pkg::MB_MARK_DONE]) && maskMarkedDone)
    || irqReq)
    else $error("marked done enable ignored");

  AST_IRQ_MARK_HALT: assert property (@(posedge refClk) disable iff (sysRst)
    ##1 !($past(statusLogged[hcpm_pkg::MB_MARK_HALT]) && maskMarkedHalt)
    || irqReq)
    else $error("marked halt enable ignored");

  // Run and monitor control
  AST_RUN_WRITE: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_RUN_CTRL, regWrStb)
    |=> chanRun == $past(regWrData[hcpm_pkg::RUN_BIT]))
    else $error("channel run bit not stored");

  AST_ARM_WRITE: assert property (@(posedge refClk) disable iff (sysRst)
    isWr(regAddr, hcpm_pkg::OFS_PMON_CTRL, regWrStb) && !(st_ff.auto && descHaltDone && counting)
    |=> st_ff.arm == $past(regWrData[hcpm_pkg::PMON_ARM_BIT]))
    else $error("monitor arm bit not stored");

  // Performance counters
  AST_NO_COUNT_IDLE: assert property (@(posedge refClk) disable iff (sysRst)
    !counting && !pmonClr && !(st_ff.auto && runRise)
    |=> $stable(st_ff.cyc) && $stable(st_ff.dat))
    else $error("counter moved while not counting");

  AST_CYC_INC: assert property (@(posedge refClk) disable iff (sysRst)
    counting && !pmonClr && !(st_ff.auto && runRise) && st_ff.cyc != CNT_ONES
    |=> st_ff.cyc == $past(st_ff.cyc) + 1'b1)
    else $error("cycle counter did not step");

  AST_DAT_INC: assert property (@(posedge refClk) disable iff (sysRst)
    counting && readBeatValid && !pmonClr && !(st_ff.auto && runRise) && st_ff.dat != CNT_ONES
    |=> st_ff.dat == $past(st_ff.dat) + 1'b1)
    else $error("beat counter did not step");

  AST_DAT_IDLE: assert property (@(posedge refClk) disable iff (sysRst)
    !readBeatValid && !pmonClr && !(st_ff.auto && runRise)
    |=> $stable(st_ff.dat))
    else $error("beat counter moved without a beat");

  AST_CLEAR: assert property (@(posedge refClk) disable iff (sysRst)
    pmonClr
    |=> st_ff.cyc == '0 && st_ff.dat == '0 && !st_ff.cycMax && !st_ff.datMax)
    else $error("monitor clear failed");

  AST_SATURATE: assert property (@(posedge refClk) disable iff (sysRst)
    st_ff.cyc == CNT_ONES && !pmonClr && !(st_ff.auto && runRise)
    |=> st_ff.cyc == CNT_ONES && st_ff.cycMax)
    else $error("cycle counter wrapped");

  AST_DAT_SATURATE: assert property (@(posedge refClk) disable iff (sysRst)
    st_ff.dat == CNT_ONES && !pmonClr && !(st_ff.auto && runRise)
    |=> st_ff.dat == CNT_ONES && st_ff.datMax)
    else $error("beat counter wrapped");

  AST_CYC_MAXED: assert property (@(posedge refClk) disable iff (sysRst)
    st_ff.cycMax
    == (st_ff.cyc == CNT_ONES))
    else $error("cycle maxed flag wrong");

  AST_DAT_MAXED: assert property (@(posedge refClk) disable iff (sysRst)
    st_ff.datMax
    == (st_ff.dat == CNT_ONES))
    else $error("beat maxed flag wrong");

  AST_AUTO_STOP: assert property (@(posedge refClk) disable iff (sysRst)
    st_ff.auto && descHaltDone && counting && !isWr(regAddr, hcpm_pkg::OFS_PMON_CTRL, regWrStb)
    |=> !st_ff.arm)
    else $error("auto stop missed");

  AST_AUTO_CLR: assert property (@(posedge refClk) disable iff (sysRst)
    st_ff.auto && runRise
    |=> st_ff.cyc == '0 && st_ff.dat == '0 && !st_ff.cycMax && !st_ff.datMax)
    else $error("auto clear missed");

  // Read port
  AST_RD_IDLE: assert property (@(posedge refClk) disable iff (sysRst)
    !regRdStb
    |=> regRdData == 32'h0000_0000)
    else $error("read data outside its cycle");

  AST_RD_MASK: assert property (@(posedge refClk) disable iff (sysRst)
    regRdStb && regAddr == hcpm_pkg::OFS_MASK
    |=> regRdData == $past(st_ff.mask))
    else $error("mask read wrong");

  AST_RD_ALIAS_ZERO: assert property (@(posedge refClk) disable iff (sysRst)
    regRdStb && (regAddr == hcpm_pkg::OFS_MASK_SET || regAddr == hcpm_pkg::OFS_MASK_CLR)
    |=> regRdData == 32'h0000_0000)
    else $error("alias read not zero");

  AST_RD_CYC_HI: assert property (@(posedge refClk) disable iff (sysRst)
    regRdStb && regAddr == hcpm_pkg::OFS_CYC_HI
    |=> regRdData[hcpm_pkg::MAXED_BIT] == $past(st_ff.cycMax))
    else $error("cycle maxed read wrong");

  AST_RD_DAT_HI: assert property (@(posedge refClk) disable iff (sysRst)
    regRdStb && regAddr == hcpm_pkg::OFS_DAT_HI
    |=> regRdData[15:10] == 6'h00 && regRdData[hcpm_pkg::MAXED_BIT] == $past(st_ff.datMax))
    else $error("beat upper word read wrong");

  AST_RD_RUN: assert property (@(posedge refClk) disable iff (sysRst)
    regRdStb && regAddr == hcpm_pkg::OFS_RUN_CTRL
    |=> regRdData == {31'h0000_0000, $past(st_ff.run)})
    else $error("run bit read wrong");

  // Main scenarios
  CVR_COUNTING: cover property (@(posedge refClk) disable iff (sysRst) counting && readBeatValid);
  CVR_IRQ: cover property (@(posedge refClk) disable iff (sysRst) $rose(irqReq));
  CVR_AUTO_STOP: cover property (@(posedge refClk) disable iff (sysRst) st_ff.auto && descHaltDone && counting);
  CVR_SATURATED: cover property (@(posedge refClk) disable iff (sysRst) st_ff.cycMax && st_ff.datMax);
  CVR_AUTO_CLEAR: cover property (@(posedge refClk) disable iff (sysRst) st_ff.auto && runRise);
endmodule

//--- test/hcpm_regs_tb.sv
`timescale 1ns/1ps
module hcpm_regs_tb;
  localparam int CW = 4;
  logic refClk = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic [31:0] statusLogged = 32'h0;
  logic descHaltDone = 1'b0;
  logic readBeatValid = 1'b0;
  logic chanRun;
  logic [63:0] wbAddr;
  logic irqReq;
  int errCount = 0;
  int checksDone = 0;
  int cycles = 0;
  int nb;
  logic [31:0] seed = 32'h0000_004D;
  logic [31:0] m, d, s, rv;
  logic [7:0] ofs [12] = '{8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hE0};

  always #2.5 refClk = ~refClk;

  // Small counters so saturation is reachable in a short run
  hcpm_regs #(.CNT_W(CW)) u_dut (.refClk(refClk), .sysRst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .statusLogged(statusLogged),
    .descHaltDone(descHaltDone), .readBeatValid(readBeatValid), .chanRun(chanRun), .wbAddr(wbAddr), .irqReq(irqReq));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] irqExp(input logic [31:0] st, input logic [31:0] mk);
    return {31'h0, |(st & mk)};
  endfunction

  task automatic nxt(output logic [31:0] v);
    repeat (32) seed = lfsr(seed);
    v = seed;
  endtask

  task automatic testDone();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge refClk);
    regWrStb <= 1'b0;
    @(posedge refClk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge refClk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge refClk);
  endtask

  task automatic irqChk(input logic [31:0] exp);
    #1 chk({31'h0, irqReq}, exp);
    @(posedge refClk);
  endtask

  always @(posedge refClk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      testDone();
    end
  end

  initial begin
    repeat (3) @(posedge refClk);
    sysRst <= 1'b0;
    @(posedge refClk);
    foreach (ofs[i]) rchk(ofs[i], 32'h0);
    nxt(d);
    wr(hcpm_pkg::OFS_WB_LO, d);
    wr(hcpm_pkg::OFS_WB_HI, ~d);
    rchk(hcpm_pkg::OFS_WB_HI, ~d);
    rchk(hcpm_pkg::OFS_WB_LO, d);
    chk(wbAddr[63:32] ^ wbAddr[31:0], 32'hFFFF_FFFF);
    for (int b = 0; b < 32; b++) begin
      statusLogged <= 32'h1 << b;
      wr(hcpm_pkg::OFS_MASK, 32'h1 << b);
      irqChk({31'h0, hcpm_pkg::MASK_VALID[b]});
      rchk(hcpm_pkg::OFS_MASK, (32'h1 << b) & hcpm_pkg::MASK_VALID);
      statusLogged <= ~(32'h1 << b);
      repeat (2) @(posedge refClk);
      irqChk(32'h0);
    end
    wr(hcpm_pkg::OFS_MASK, 32'h0);
    m = 32'h0;
    repeat (24) begin
      nxt(d);
      nxt(s);
      statusLogged <= s;
      case (seed[1:0])
        2'h0: wr(hcpm_pkg::OFS_MASK, d);
        2'h1: wr(hcpm_pkg::OFS_MASK_SET, d);
        default: wr(hcpm_pkg::OFS_MASK_CLR, d);
      endcase
      m = (seed[1:0] == 2'h0) ? d & hcpm_pkg::MASK_VALID : (seed[1:0] == 2'h1) ? m | (d & hcpm_pkg::MASK_VALID) : m & ~d;
      irqChk(irqExp(s, m));
      rchk(hcpm_pkg::OFS_MASK, m);
    end
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h4);
    repeat (5) @(posedge refClk);
    rchk(hcpm_pkg::OFS_CYC_LO, 32'h0);
    wr(hcpm_pkg::OFS_RUN_CTRL, 32'h1);
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h0);
    chk({31'h0, chanRun}, 32'h1);
    rchk(hcpm_pkg::OFS_CYC_LO, 32'h2);
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h2);
    rchk(hcpm_pkg::OFS_CYC_LO, 32'h0);
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h4);
    nb = 0;
    for (int i = 0; i < 8; i++) begin
      readBeatValid <= seed[0];
      nb += int'(seed[0]);
      seed = lfsr(seed);
      @(posedge refClk);
    end
    readBeatValid <= 1'b0;
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h0);
    rchk(hcpm_pkg::OFS_CYC_LO, 32'hA);
    rchk(hcpm_pkg::OFS_DAT_LO, 32'(nb));
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h4);
    readBeatValid <= 1'b1;
    repeat (20) @(posedge refClk);
    readBeatValid <= 1'b0;
    rchk(hcpm_pkg::OFS_CYC_LO, 32'hF);
    rchk(hcpm_pkg::OFS_CYC_HI, 32'h0001_0000);
    rchk(hcpm_pkg::OFS_DAT_HI, 32'h0001_0000);
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h2);
    rchk(hcpm_pkg::OFS_DAT_HI, 32'h0);
    wr(hcpm_pkg::OFS_PMON_CTRL, 32'h5);
    readBeatValid <= 1'b1;
    wr(hcpm_pkg::OFS_RUN_CTRL, 32'h0);
    readBeatValid <= 1'b0;
    wr(hcpm_pkg::OFS_RUN_CTRL, 32'h1);
    rchk(hcpm_pkg::OFS_DAT_LO, 32'h0);
    descHaltDone <= 1'b1;
    @(posedge refClk);
    descHaltDone <= 1'b0;
    @(posedge refClk);
    rchk(hcpm_pkg::OFS_PMON_CTRL, 32'h1);
    regAddr <= hcpm_pkg::OFS_CYC_LO;
    regRdStb <= 1'b1;
    @(posedge refClk);
    regRdStb <= 1'b0;
    #1 rv = regRdData;
    repeat (4) @(posedge refClk);
    rchk(hcpm_pkg::OFS_CYC_LO, rv);
    testDone();
  end
endmodule
